// ---- pkg/radio_ctl_pkg.sv ----
// constants for the radio control and rate configuration registers
package radio_ctl_pkg;
  // register addresses on the serial register port
  localparam logic [5:0] ADDR_RADIO_CONTROL = 6'h03;
  localparam logic [5:0] ADDR_RATE_CONFIG = 6'h04;
  localparam logic [7:0] RADIO_CONTROL_RST = 8'h00;
  localparam logic [2:0] RATE_CONFIG_RST = 3'h0;
  // control register fields
  localparam int CTL_RX_EN = 7;
  localparam int CTL_TX_EN = 6;
  localparam int CTL_CODE_HALF = 5;
  localparam int CTL_SETTLE_BY_COUNT = 4;
  localparam int CTL_AMP_OVERRIDE = 3;
  localparam int CTL_AMP_ON = 2;
  localparam int CTL_SYN_OVERRIDE = 1;
  localparam int CTL_SYN_ON = 0;
  // rate register fields
  localparam int RATE_CODE_32 = 2;
  localparam int RATE_DOUBLE = 1;
  localparam int RATE_OVS_12X = 0;
  localparam int RATE_W = 3;
  // serial frame layout
  localparam int FRAME_WR_BIT = 7;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // settle count unit
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_UNIT_NS = 2000;
  localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [6:0] UNIT_LAST = 7'(SETTLE_UNIT_CYC - 1);
  // synthesizer settle sequencer, one bit changes on each forward step
  typedef enum logic [1:0] {
    SYN_OFF = 2'h0,
    SYN_SETTLING = 2'h1,
    SYN_READY = 2'h3
  } syn_state_t;
endpackage

// ---- rtl/radio_control_rate_regs.sv ----
// control and rate registers behind the serial port, with synthesizer and amplifier control
`timescale 1ns/1ps
module radio_control_rate_regs
  import radio_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // serial register port
  input wire logic ser_clk_i,
  input wire logic ser_sel_n_i,
  input wire logic ser_din_i,
  output logic ser_dout_o,
  output logic ser_dout_oe_n_o,
  // synthesizer interface
  input wire logic [7:0] settle_count_i,
  input wire logic syn_lock_i,
  output logic synth_on_o,
  output logic synth_settled_o,
  // radio mode outputs
  output logic rx_mode_o,
  output logic tx_mode_o,
  output logic amp_on_o,
  output logic code_half_choice_o,
  output logic code_32_o,
  output logic double_rate_o,
  output logic ovs_12x_o
);

  // pin synchronisers, reset to idle pin levels: select high, clock, data and lock low
  localparam logic [3:0] PIN_IDLE = 4'h4;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic ser_clk_prev_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
      ser_clk_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= {syn_lock_i, ser_sel_n_i, ser_clk_i, ser_din_i};
      pin_sync_r <= pin_meta_r;
      ser_clk_prev_r <= pin_sync_r[1];
    end
  end

  logic din_s, sclk_s, sel_n_s, lock_s, sclk_rise, sclk_fall;
  assign din_s = pin_sync_r[0];
  assign sclk_s = pin_sync_r[1];
  assign sel_n_s = pin_sync_r[2];
  assign lock_s = pin_sync_r[3];
  assign sclk_rise = sclk_s & ~ser_clk_prev_r & ~sel_n_s;
  assign sclk_fall = ~sclk_s & ser_clk_prev_r & ~sel_n_s;

  // serial frame and register group
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] in_sh_r, in_sh_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] out_sh_r, out_sh_nxt;
  logic [7:0] control_r, control_nxt;
  logic [RATE_W-1:0] rate_r, rate_nxt;
  logic [7:0] shifted_in;

  function automatic logic [7:0] read_value(input logic [5:0] addr, input logic [7:0] ctl,
                                            input logic [RATE_W-1:0] rate);
    if (addr == ADDR_RADIO_CONTROL) begin
      read_value = ctl;
    end else if (addr == ADDR_RATE_CONFIG) begin
      read_value = {5'h00, rate};
    end else begin
      read_value = 8'h00;
    end
  endfunction

  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    in_sh_nxt = in_sh_r;
    cmd_nxt = cmd_r;
    out_sh_nxt = out_sh_r;
    control_nxt = control_r;
    rate_nxt = rate_r;
    shifted_in = {in_sh_r[6:0], din_s};
    if (sel_n_s) begin
      bit_cnt_nxt = 5'h00;
    end else if (sclk_rise && bit_cnt_r < FRAME_BITS) begin
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      in_sh_nxt = shifted_in;
      if (bit_cnt_r == CMD_BITS - 5'h01) begin
        cmd_nxt = shifted_in;
        out_sh_nxt = read_value(shifted_in[5:0], control_r, rate_r);
      end
      if (bit_cnt_r == FRAME_BITS - 5'h01 && cmd_r[FRAME_WR_BIT]) begin
        if (cmd_r[5:0] == ADDR_RADIO_CONTROL) begin
          control_nxt = shifted_in;
        end else if (cmd_r[5:0] == ADDR_RATE_CONFIG) begin
          rate_nxt = shifted_in[RATE_W-1:0];
        end
      end
    end else if (sclk_fall && bit_cnt_r > CMD_BITS) begin
      out_sh_nxt = {out_sh_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt_r <= 5'h00;
      in_sh_r <= 8'h00;
      cmd_r <= 8'h00;
      out_sh_r <= 8'h00;
      control_r <= RADIO_CONTROL_RST;
      rate_r <= RATE_CONFIG_RST;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      in_sh_r <= in_sh_nxt;
      cmd_r <= cmd_nxt;
      out_sh_r <= out_sh_nxt;
      control_r <= control_nxt;
      rate_r <= rate_nxt;
    end
  end

  assign ser_dout_o = out_sh_r[7];
  assign ser_dout_oe_n_o = ~(~sel_n_s && bit_cnt_r >= CMD_BITS && ~cmd_r[FRAME_WR_BIT]);

  // decoded modes
  logic code_32, syn_want;
  assign code_32 = rate_r[RATE_CODE_32];
  assign rx_mode_o = control_r[CTL_RX_EN];
  assign tx_mode_o = control_r[CTL_TX_EN];
  assign code_32_o = code_32;
  assign code_half_choice_o = code_32 & control_r[CTL_CODE_HALF];
  assign double_rate_o = code_32 & rate_r[RATE_DOUBLE];
  assign ovs_12x_o = code_32 & ~rate_r[RATE_DOUBLE] & rate_r[RATE_OVS_12X];
  // manual or automatic synthesizer enable
  assign syn_want = control_r[CTL_SYN_OVERRIDE] ? control_r[CTL_SYN_ON]
                  : (control_r[CTL_RX_EN] | control_r[CTL_TX_EN]);
  assign synth_on_o = syn_want;

  // synthesizer settle sequencer group
  syn_state_t state_r, state_nxt;
  logic [6:0] cyc_cnt_r, cyc_cnt_nxt;
  logic [7:0] unit_cnt_r, unit_cnt_nxt;
  logic by_count;
  assign by_count = control_r[CTL_SETTLE_BY_COUNT];

  always_comb begin
    state_nxt = state_r;
    cyc_cnt_nxt = cyc_cnt_r;
    unit_cnt_nxt = unit_cnt_r;
    case (state_r)
      SYN_OFF: begin
        cyc_cnt_nxt = 7'h00;
        unit_cnt_nxt = 8'h00;
        if (syn_want) begin
          state_nxt = SYN_SETTLING;
        end
      end
      SYN_SETTLING: begin
        if (!syn_want) begin
          state_nxt = SYN_OFF;
        end else if (by_count) begin
          if (unit_cnt_r >= settle_count_i) begin
            state_nxt = SYN_READY;
          end else if (cyc_cnt_r == UNIT_LAST) begin
            cyc_cnt_nxt = 7'h00;
            unit_cnt_nxt = unit_cnt_r + 8'h01;
          end else begin
            cyc_cnt_nxt = cyc_cnt_r + 7'h01;
          end
        end else if (lock_s) begin
          state_nxt = SYN_READY;
        end
      end
      SYN_READY: begin
        if (!syn_want) begin
          state_nxt = SYN_OFF;
        end
      end
      default: begin
        state_nxt = SYN_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= SYN_OFF;
      cyc_cnt_r <= 7'h00;
      unit_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
      unit_cnt_r <= unit_cnt_nxt;
    end
  end

  assign synth_settled_o = (state_r == SYN_READY);
  // manual or automatic amplifier enable
  assign amp_on_o = control_r[CTL_AMP_OVERRIDE] ? control_r[CTL_AMP_ON]
                  : (control_r[CTL_TX_EN] & synth_settled_o);

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic ctl_wr, rate_wr;
  assign ctl_wr = sclk_rise && bit_cnt_r == FRAME_BITS - 5'h01 && cmd_r[FRAME_WR_BIT]
                  && cmd_r[5:0] == ADDR_RADIO_CONTROL;
  assign rate_wr = sclk_rise && bit_cnt_r == FRAME_BITS - 5'h01 && cmd_r[FRAME_WR_BIT]
                   && cmd_r[5:0] == ADDR_RATE_CONFIG;

  // cycles spent settling, saturating, for the settle time check
  logic [15:0] settle_age_r, settle_age_nxt;
  logic [15:0] settle_min;
  assign settle_min = 16'(settle_count_i * SETTLE_UNIT_CYC);

  always_comb begin
    settle_age_nxt = 16'h0000;
    if (state_r == SYN_SETTLING && settle_age_r != 16'hFFFF) begin
      settle_age_nxt = settle_age_r + 16'h0001;
    end else if (state_r == SYN_SETTLING) begin
      settle_age_nxt = settle_age_r;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_age_r <= 16'h0000;
    end else begin
      settle_age_r <= settle_age_nxt;
    end
  end

  a_rx_mode_write: assert property (ctl_wr |=> rx_mode_o == $past(in_sh_r[6]))
    else $error("receive mode does not follow written bit");
  a_tx_mode_write: assert property (ctl_wr |=> tx_mode_o == $past(in_sh_r[5]))
    else $error("transmit mode does not follow written bit");
  a_code_half_gate: assert property (!code_32_o |-> !code_half_choice_o)
    else $error("code half choice active with 64-chip codes");
  a_code_half_sel: assert property (ctl_wr && code_32 |=>
    code_half_choice_o == $past(in_sh_r[4])) else $error("code half choice wrong");
  a_settle_count_min: assert property (state_r == SYN_SETTLING && by_count && syn_want
    && unit_cnt_r < settle_count_i |=> !synth_settled_o) else $error("settled before count");
  a_settle_lock: assert property (state_r == SYN_SETTLING && !by_count && syn_want && lock_s
    |=> synth_settled_o) else $error("lock did not settle synthesizer");
  a_amp_manual: assert property (control_r[CTL_AMP_OVERRIDE] |->
    amp_on_o == control_r[CTL_AMP_ON]) else $error("manual amplifier state wrong");
  a_amp_auto_on: assert property (!control_r[CTL_AMP_OVERRIDE] && tx_mode_o
    && state_nxt == SYN_READY && control_nxt == control_r |=> amp_on_o)
    else $error("automatic amplifier not on");
  a_amp_bit_ignored: assert property (!control_r[CTL_AMP_OVERRIDE] && !tx_mode_o
    |-> !amp_on_o) else $error("amplifier on without transmit");
  a_syn_manual: assert property (control_r[CTL_SYN_OVERRIDE] |->
    synth_on_o == control_r[CTL_SYN_ON]) else $error("manual synthesizer state wrong");
  a_syn_auto: assert property (!control_r[CTL_SYN_OVERRIDE] |->
    synth_on_o == (rx_mode_o | tx_mode_o)) else $error("automatic synthesizer wrong");
  a_rate_code_width: assert property (rate_wr |=> code_32_o == $past(in_sh_r[1]))
    else $error("code width not stored");
  a_rate_double: assert property (double_rate_o |-> code_32_o && !ovs_12x_o)
    else $error("double rate decode wrong");
  a_rate_reserved: assert property (rate_wr |=> rate_r == $past(shifted_in[RATE_W-1:0]))
    else $error("rate register write wrong");
  a_settle_count_time: assert property (state_r == SYN_SETTLING && by_count
    && state_nxt == SYN_READY |-> settle_age_r >= settle_min)
    else $error("count settle time too short");
  a_settle_no_lock: assert property (state_r == SYN_SETTLING && !by_count && !lock_s
    |=> !synth_settled_o) else $error("settled without lock");
  a_syn_off_drop: assert property (!synth_on_o |=> !synth_settled_o)
    else $error("settled while synthesizer off");
  a_ovs_gate: assert property (ovs_12x_o |-> code_32_o && !double_rate_o)
    else $error("oversampling decode wrong");
  a_half_lower: assert property (!control_r[CTL_CODE_HALF] |-> !code_half_choice_o)
    else $error("upper code half without select bit");
  a_ctl_hold: assert property (!ctl_wr |=> $stable(control_r))
    else $error("control register changed without write");
  a_rate_hold: assert property (!rate_wr |=> $stable(rate_r))
    else $error("rate register changed without write");

  c_settle_by_count: cover property (state_r == SYN_SETTLING && by_count ##1 synth_settled_o);
  c_settle_by_lock: cover property (state_r == SYN_SETTLING && !by_count ##1 synth_settled_o);
  c_auto_amp_on: cover property (!control_r[CTL_AMP_OVERRIDE] && amp_on_o);
  c_reg_read: cover property (!ser_dout_oe_n_o);
  c_code_upper: cover property (code_half_choice_o);

endmodule

// ---- verification/host_port_model.sv ----
// host side model of the serial register port
`timescale 1ns/1ps
module host_port_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic ser_clk_o,
  output logic ser_sel_n_o,
  output logic ser_din_o,
  input wire logic ser_dout_i,
  input wire logic ser_dout_oe_n_i
);
  localparam int HALF = 6;
  initial begin
    ser_clk_o = 1'b0;
    ser_sel_n_o = 1'b1;
    ser_din_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one frame, mode 0, msb first; callers keep rate codes valid
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {wr, 1'b0, a, d};
    q = 8'h00;
    wait_clk(1);
    ser_sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_din_o = f[i];
      wait_clk(HALF);
      ser_clk_o = 1'b1;
      if (i < 8) q = {q[6:0], (ser_dout_oe_n_i === 1'b0) ? ser_dout_i : 1'bx};
      wait_clk(HALF);
      ser_clk_o = 1'b0;
    end
    ser_sel_n_o = 1'b1;
    ser_din_o = ~ser_din_o;
    wait_clk(4);
  endtask
endmodule

// ---- verification/radio_control_rate_regs_tb.sv ----
// self-checking bench for the control and rate registers
`timescale 1ns/1ps
module radio_control_rate_regs_tb;
  import radio_ctl_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sck, sel_n, din, dout, oe_n, syn_on, settled, rx, tx, amp, half, c32, dbl, ovs;
  logic [7:0] settle_count = 8'h01;
  logic syn_lock = 1'b0;
  logic [7:0] rd;
  int err_count = 0;
  int cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  radio_control_rate_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ser_clk_i(sck),
    .ser_sel_n_i(sel_n), .ser_din_i(din), .ser_dout_o(dout), .ser_dout_oe_n_o(oe_n),
    .settle_count_i(settle_count), .syn_lock_i(syn_lock), .synth_on_o(syn_on),
    .synth_settled_o(settled), .rx_mode_o(rx), .tx_mode_o(tx), .amp_on_o(amp),
    .code_half_choice_o(half), .code_32_o(c32), .double_rate_o(dbl), .ovs_12x_o(ovs));
  host_port_model HOST (.clk_i(clk_i), .ser_clk_o(sck), .ser_sel_n_o(sel_n),
    .ser_din_o(din), .ser_dout_i(dout), .ser_dout_oe_n_i(oe_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    HOST.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    HOST.xfer(1'b0, a, 8'h00, rd);
    chk(rd, exp);
  endtask
  function automatic logic [7:0] outs();
    return {rx, tx, half, amp, syn_on, settled, 1'b0, oe_n};
  endfunction
  function automatic logic [7:0] rate_outs();
    return {5'h00, c32, dbl, ovs};
  endfunction
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_settled(input int n);
    for (int i = 0; i < n && settled !== 1'b1; i++) wait_clk(1);
  endtask
  task automatic test_reset();
    chk(outs(), 8'h01);
    rdchk(ADDR_RADIO_CONTROL, 8'h00);
    rdchk(ADDR_RATE_CONFIG, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_modes();
    wr(ADDR_RADIO_CONTROL, 8'hE0);
    chk(outs(), 8'hC9);
    wr(ADDR_RATE_CONFIG, 8'hFC);
    chk(outs(), 8'hE9);
    rdchk(ADDR_RATE_CONFIG, 8'h04);
    chk(rate_outs(), 8'h04);
    wr(6'h05, 8'hFF);
    rdchk(6'h05, 8'h00);
    rdchk(ADDR_RADIO_CONTROL, 8'hE0);
    wr(ADDR_RADIO_CONTROL, 8'h00);
    $display("test modes done");
  endtask
  task automatic test_rates();
    logic [2:0] codes [4] = '{3'h0, 3'h4, 3'h6, 3'h5};
    foreach (codes[i]) begin
      wr(ADDR_RATE_CONFIG, {5'h00, codes[i]});
      chk(rate_outs(), {5'h00, codes[i]});
      rdchk(ADDR_RATE_CONFIG, {5'h00, codes[i]});
    end
    wr(ADDR_RATE_CONFIG, 8'h00);
    $display("test rates done");
  endtask
  task automatic test_manual();
    wr(ADDR_RADIO_CONTROL, 8'h0F);
    chk(outs(), 8'h19);
    wr(ADDR_RADIO_CONTROL, 8'h0A);
    chk(outs(), 8'h01);
    wr(ADDR_RADIO_CONTROL, 8'h05);
    chk(outs(), 8'h01);
    wr(ADDR_RADIO_CONTROL, 8'h0D);
    chk(outs(), 8'h11);
    $display("test manual done");
  endtask
  // auto amplifier and synthesizer, count mode preferred
  task automatic test_count();
    syn_lock = 1'b1;
    wr(ADDR_RADIO_CONTROL, 8'h50);
    chk(outs(), 8'h49);
    wait_clk(40);
    chk(outs(), 8'h49);
    wait_settled(100);
    chk(outs(), 8'h5D);
    wr(ADDR_RADIO_CONTROL, 8'h00);
    chk(outs(), 8'h01);
    $display("test count done");
  endtask
  task automatic test_lock();
    syn_lock = 1'b0;
    wr(ADDR_RADIO_CONTROL, 8'h40);
    wait_clk(100);
    chk(outs(), 8'h49);
    syn_lock = 1'b1;
    wait_settled(8);
    chk(outs(), 8'h5D);
    wr(ADDR_RADIO_CONTROL, 8'h00);
    $display("test lock done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    wait_clk(40000);
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    wait_clk(2);
    reset_n_i = 1'b1;
    wait_clk(4);
    test_reset();
    test_modes();
    test_rates();
    test_manual();
    test_count();
    test_lock();
    complete_run();
  end
endmodule
